// [design/csf_pkg.sv]
// Constants for the core status and fast shadow stack block.
// Assumes one core clock; shared by the core context module and its ALU.
package csf_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BANK_W = 4;
   localparam int unsigned TPTR_W = 21;
   // Status field positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_NC = 1;
   localparam int unsigned FLAG_Z = 2;
   localparam int unsigned FLAG_SRE = 3;
   localparam int unsigned FLAG_N = 4;
   localparam logic [7:0] STATUS_IMPL_MASK = 8'h1f;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] WACC_RESET = 8'h00;
   localparam logic [3:0] BANK_RESET = 4'h0;
   // Count of cycles the device reset pulse is held after a stack fault
   localparam int unsigned STACK_RST_CYCLES = 4;
   typedef enum logic [2:0] {
      CSF_OP_ADD = 3'h0,
      CSF_OP_SUB = 3'h1,
      CSF_OP_AND = 3'h2,
      CSF_OP_IOR = 3'h3,
      CSF_OP_XOR = 3'h4,
      CSF_OP_CLR = 3'h5,
      CSF_OP_MOV = 3'h6
   } csf_op_e;
   typedef enum logic [1:0] {
      CSF_RST_IDLE = 2'b01,
      CSF_RST_HOLD = 2'b10
   } csf_rst_e;
endpackage : csf_pkg

// [design/csf_alu.sv]
// ALU for the core context block: result and arithmetic flags.
// Assumes operands are stable within the cycle; purely combinational.
`timescale 1ns/1ns
module csf_alu #(
   parameter int unsigned W = 8
) (
   input wire logic [2:0] op,
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic [W-1:0] flags_in,
   output logic [W-1:0] result,
   output logic [W-1:0] flags_out,
   output logic flags_touched
);
   logic [W:0] sum;
   logic [4:0] nib;
   logic [W-1:0] bb;
   logic sub;
   always_comb begin
      sub = (op == csf_pkg::CSF_OP_SUB);
      bb = sub ? ~b : b;
      // Subtraction adds the complement plus one, so carry means no borrow
      sum = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, sub};
      nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
      flags_out = flags_in;
      flags_touched = 1'b1;
      unique case (op)
         csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB: begin
            result = sum[W-1:0];
            flags_out[csf_pkg::FLAG_C] = sum[W];
            flags_out[csf_pkg::FLAG_NC] = nib[4];
            flags_out[csf_pkg::FLAG_SRE] = (a[W-1] == bb[W-1]) && (sum[W-1] != a[W-1]);
         end
         csf_pkg::CSF_OP_AND: result = a & b;
         csf_pkg::CSF_OP_IOR: result = a | b;
         csf_pkg::CSF_OP_XOR: result = a ^ b;
         csf_pkg::CSF_OP_CLR: result = '0;
         default: begin
            result = b;
            flags_touched = 1'b0;
         end
      endcase
      if (flags_touched) begin
         flags_out[csf_pkg::FLAG_Z] = (result == '0);
         // A clear moves only the zero flag, the sign flag keeps its value
         if (op != csf_pkg::CSF_OP_CLR) begin
            flags_out[csf_pkg::FLAG_N] = result[W-1];
         end
      end
   end
endmodule : csf_alu

// [design/csf_core.sv]
// Core context logic: status register, shadow stack, stack fault reset,
// computed jump and table pointer/latch.
// Assumes the decoder gives one-cycle strobes and program memory answers
// table reads combinationally.
`timescale 1ns/1ns
module csf_core #(
   parameter int unsigned RST_CYCLES = csf_pkg::STACK_RST_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic stack_reset_enable,
   input wire logic stack_full_evt,
   input wire logic stack_underflow_evt,
   input wire logic stack_full_flag_clr,
   input wire logic stack_underflow_flag_clr,
   output logic stack_full_flag,
   output logic stack_underflow_flag,
   output logic device_reset,
   input wire logic irq_vector,
   input wire logic fast_call,
   input wire logic interrupt_return_instr,
   input wire logic fast_return,
   input wire logic return_literal_instr,
   input wire logic [7:0] literal,
   input wire logic alu_en,
   input wire logic [2:0] alu_op,
   input wire logic [7:0] alu_operand,
   input wire logic alu_src_status,
   input wire logic dest_status,
   input wire logic dest_working_accumulator,
   input wire logic status_wr,
   input wire logic [7:0] status_wdata,
   input wire logic wacc_wr,
   input wire logic [7:0] wacc_wdata,
   input wire logic bank_wr,
   input wire logic [3:0] bank_wdata,
   output logic [7:0] alu_result,
   output logic [7:0] alu_flags,
   output logic [7:0] working_accumulator,
   output logic [3:0] bank_select_reg,
   input wire logic add_w_to_file,
   input wire logic [7:0] pc_low_in,
   output logic [7:0] pc_low_byte,
   output logic pc_low_load,
   output logic return_pop,
   input wire logic tptr_wr,
   input wire logic [20:0] tptr_wdata,
   input wire logic tbl_rd,
   input wire logic tbl_wr,
   input wire logic tbl_inc,
   input wire logic [15:0] prog_word,
   input wire logic latch_wr,
   input wire logic [7:0] latch_wdata,
   output logic [20:0] table_pointer,
   output logic [7:0] table_latch,
   output logic [7:0] prog_wr_byte,
   output logic prog_wr_en
);
   logic [7:0] shadow_status;
   logic [7:0] shadow_wacc;
   logic [3:0] shadow_bank;
   logic [7:0] next_result;
   logic [7:0] next_flags;
   logic flags_touched;
   logic [7:0] alu_a;
   logic restore;
   logic save;
   csf_pkg::csf_rst_e rst_state;
   logic [7:0] rst_cnt;

   // Status may feed the ALU like any register
   assign alu_a = alu_src_status ? alu_flags : working_accumulator;
   assign save = irq_vector | fast_call;
   // A literal return never restores; plain and interrupt returns do with the fast option
   assign restore = fast_return & ~return_literal_instr;

   csf_alu #(.W(8)) u_alu (
      .op(alu_op),
      .a(alu_a),
      .b(alu_operand),
      .flags_in(alu_flags),
      .result(next_result),
      .flags_out(next_flags),
      .flags_touched(flags_touched)
   );

   // Stack fault flags: events win over a software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         stack_full_flag <= 1'b0;
         stack_underflow_flag <= 1'b0;
      end else begin
         if (stack_full_evt) begin
            stack_full_flag <= 1'b1;
         end else if (stack_full_flag_clr) begin
            stack_full_flag <= 1'b0;
         end
         if (stack_underflow_evt) begin
            stack_underflow_flag <= 1'b1;
         end else if (stack_underflow_flag_clr) begin
            stack_underflow_flag <= 1'b0;
         end
      end
   end

   // Reset pulse starts on the same edge that sets the flag, so both are visible together
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_state <= csf_pkg::CSF_RST_IDLE;
         rst_cnt <= 8'h00;
      end else begin
         unique case (rst_state)
            csf_pkg::CSF_RST_IDLE: begin
               if (stack_reset_enable && (stack_full_evt || stack_underflow_evt)) begin
                  rst_state <= csf_pkg::CSF_RST_HOLD;
                  rst_cnt <= 8'(RST_CYCLES - 1);
               end
            end
            csf_pkg::CSF_RST_HOLD: begin
               if (rst_cnt == 8'h00) begin
                  rst_state <= csf_pkg::CSF_RST_IDLE;
               end else begin
                  rst_cnt <= rst_cnt - 8'h01;
               end
            end
            default: rst_state <= csf_pkg::CSF_RST_IDLE;
         endcase
      end
   end
   assign device_reset = (rst_state == csf_pkg::CSF_RST_HOLD);

   // Shadow copies have no read or write path from software
   always_ff @(posedge clk) begin
      if (rst) begin
         shadow_status <= csf_pkg::STATUS_RESET;
         shadow_wacc <= csf_pkg::WACC_RESET;
         shadow_bank <= csf_pkg::BANK_RESET;
      end else if (save) begin
         shadow_status <= alu_flags;
         shadow_wacc <= working_accumulator;
         shadow_bank <= bank_select_reg;
      end
   end

   // Status register; restore beats any same-cycle write
   always_ff @(posedge clk) begin
      if (rst) begin
         alu_flags <= csf_pkg::STATUS_RESET;
      end else if (restore) begin
         alu_flags <= shadow_status;
      end else if (alu_en && flags_touched) begin
         // Flag update wins over a write of the result to status
         alu_flags <= next_flags & csf_pkg::STATUS_IMPL_MASK;
      end else if (alu_en && dest_status) begin
         alu_flags <= next_result & csf_pkg::STATUS_IMPL_MASK;
      end else if (status_wr) begin
         alu_flags <= status_wdata & csf_pkg::STATUS_IMPL_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         working_accumulator <= csf_pkg::WACC_RESET;
      end else if (restore) begin
         working_accumulator <= shadow_wacc;
      end else if (return_literal_instr) begin
         working_accumulator <= literal;
      end else if (alu_en && dest_working_accumulator) begin
         working_accumulator <= next_result;
      end else if (wacc_wr) begin
         working_accumulator <= wacc_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bank_select_reg <= csf_pkg::BANK_RESET;
      end else if (restore) begin
         bank_select_reg <= shadow_bank;
      end else if (bank_wr) begin
         bank_select_reg <= bank_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alu_result <= 8'h00;
      end else if (alu_en) begin
         alu_result <= next_result;
      end
   end

   // Computed jump: odd offsets would land mid-word, software keeps them even
   always_ff @(posedge clk) begin
      if (rst) begin
         pc_low_byte <= 8'h00;
         pc_low_load <= 1'b0;
      end else begin
         pc_low_load <= add_w_to_file;
         if (add_w_to_file) begin
            pc_low_byte <= pc_low_in + working_accumulator;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         return_pop <= 1'b0;
      end else begin
         return_pop <= return_literal_instr | interrupt_return_instr | fast_return;
      end
   end

   // Table access: bit 0 of the pointer picks the byte within the word
   always_ff @(posedge clk) begin
      if (rst) begin
         table_pointer <= '0;
      end else if (tptr_wr) begin
         table_pointer <= tptr_wdata;
      end else if ((tbl_rd || tbl_wr) && tbl_inc) begin
         table_pointer <= table_pointer + 21'h000001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         table_latch <= 8'h00;
      end else if (tbl_rd) begin
         table_latch <= table_pointer[0] ? prog_word[15:8] : prog_word[7:0];
      end else if (latch_wr) begin
         table_latch <= latch_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prog_wr_byte <= 8'h00;
         prog_wr_en <= 1'b0;
      end else begin
         prog_wr_en <= tbl_wr;
         if (tbl_wr) begin
            prog_wr_byte <= table_latch;
         end
      end
   end

   // Cycles the current device reset has stood, so its span is checked as a count
   logic [7:0] hold_seen;
   always_ff @(posedge clk) begin
      if (rst || !device_reset) begin
         hold_seen <= 8'h00;
      end else begin
         hold_seen <= hold_seen + 8'h01;
      end
   end

   a_fault_reset: assert property (@(posedge clk) disable iff (rst)
      (stack_reset_enable && stack_full_evt && !device_reset) |=> device_reset && stack_full_flag)
      else $error("stack fault did not reset");
   a_underflow_reset: assert property (@(posedge clk) disable iff (rst)
      (stack_reset_enable && stack_underflow_evt && !device_reset)
      |=> device_reset && stack_underflow_flag)
      else $error("stack underflow did not reset");
   a_reset_length: assert property (@(posedge clk) disable iff (rst)
      $fell(device_reset) |-> hold_seen == 8'(RST_CYCLES))
      else $error("device reset length wrong");
   a_no_reset: assert property (@(posedge clk) disable iff (rst)
      (!device_reset && !stack_reset_enable) |=> !device_reset)
      else $error("reset without enable");
   a_flag_set: assert property (@(posedge clk) disable iff (rst)
      stack_full_evt |=> stack_full_flag)
      else $error("full flag not set");
   a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
      (stack_underflow_flag && !stack_underflow_flag_clr) |=> stack_underflow_flag)
      else $error("underflow flag lost");
   a_shadow_save: assert property (@(posedge clk) disable iff (rst)
      save |=> shadow_wacc == $past(working_accumulator)
      && shadow_status == $past(alu_flags) && shadow_bank == $past(bank_select_reg))
      else $error("shadow not saved");
   a_fast_restore: assert property (@(posedge clk) disable iff (rst)
      (fast_return && !return_literal_instr) |=> working_accumulator == $past(shadow_wacc)
      && alu_flags == $past(shadow_status) && bank_select_reg == $past(shadow_bank))
      else $error("fast return did not restore");
   a_literal_load: assert property (@(posedge clk) disable iff (rst)
      (return_literal_instr) |=> working_accumulator == $past(literal) && return_pop)
      else $error("literal not loaded");
   a_status_operand: assert property (@(posedge clk) disable iff (rst)
      (alu_en && alu_src_status && alu_op == csf_pkg::CSF_OP_AND && dest_working_accumulator && !restore
      && !return_literal_instr)
      |=> working_accumulator == ($past(alu_flags) & $past(alu_operand)))
      else $error("status operand wrong");
   a_status_clear: assert property (@(posedge clk) disable iff (rst)
      (alu_en && dest_status && alu_op == csf_pkg::CSF_OP_CLR && !restore)
      |=> alu_flags == (($past(alu_flags) & 8'h1b) | 8'h04))
      else $error("status clear wrong");
   a_status_upper: assert property (@(posedge clk) disable iff (rst)
      alu_flags[7:5] == 3'h0)
      else $error("status upper bits set");
   a_jump_target: assert property (@(posedge clk) disable iff (rst)
      add_w_to_file |=> pc_low_load
      && pc_low_byte == 8'($past(pc_low_in) + $past(working_accumulator)))
      else $error("computed jump wrong");
   a_table_byte: assert property (@(posedge clk) disable iff (rst)
      (tbl_rd && !table_pointer[0]) |=> table_latch == $past(prog_word[7:0]))
      else $error("table low byte wrong");
   a_table_high: assert property (@(posedge clk) disable iff (rst)
      (tbl_rd && table_pointer[0]) |=> table_latch == $past(prog_word[15:8]))
      else $error("table high byte wrong");
   a_pointer_step: assert property (@(posedge clk) disable iff (rst)
      (tbl_rd && tbl_inc && !tptr_wr) |=> table_pointer == $past(table_pointer) + 21'h000001)
      else $error("table pointer step wrong");
   a_table_write: assert property (@(posedge clk) disable iff (rst)
      tbl_wr |=> prog_wr_en && prog_wr_byte == $past(table_latch))
      else $error("table write byte wrong");
   c_fault_reset: cover property (@(posedge clk) disable iff (rst)
      stack_reset_enable && stack_full_evt);
   c_fast_pair: cover property (@(posedge clk) disable iff (rst)
      fast_call ##[1:8] fast_return);
   c_status_dest: cover property (@(posedge clk) disable iff (rst)
      alu_en && dest_status && flags_touched);
   c_nested_save: cover property (@(posedge clk) disable iff (rst)
      irq_vector ##[1:8] irq_vector);
   c_table_high: cover property (@(posedge clk) disable iff (rst)
      tbl_rd && table_pointer[0]);
endmodule : csf_core

// [bench/csf_prog_mem_model.sv]
// Program memory model standing behind the table read port of the core.
// Assumes a combinational answer addressed by the byte pointer of the core.
`timescale 1ns/1ns
module csf_prog_mem_model (
   input wire logic [20:0] table_pointer,
   output logic [15:0] prog_word
);
   // Both bytes differ from each other, so a wrong byte select shows up
   assign prog_word = {table_pointer[8:1] ^ 8'h5a, table_pointer[8:1]};
endmodule : csf_prog_mem_model

// [bench/csf_core_tb.sv]
// Self-checking bench for the core context block with a program memory model.
// Assumes one 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ns
module csf_core_tb;
   typedef struct {string n; logic [31:0] v;} csf_note_s;
   csf_note_s notes[$];
   csf_note_s nt;
   int failures = 0;
   int checked = 0;
   logic [31:0] seed = 32'hfd076aff;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stack_reset_enable = 0, stack_full_evt = 0, stack_underflow_evt = 0;
   logic stack_full_flag_clr = 0, stack_underflow_flag_clr = 0, irq_vector = 0, fast_call = 0;
   logic interrupt_return_instr = 0, fast_return = 0, return_literal_instr = 0, alu_en = 0;
   logic alu_src_status = 0, dest_status = 0, dest_working_accumulator = 0, status_wr = 0, wacc_wr = 0;
   logic bank_wr = 0, add_w_to_file = 0, tptr_wr = 0, tbl_rd = 0, tbl_wr = 0, tbl_inc = 0;
   logic latch_wr = 0;
   logic [2:0] alu_op = '0;
   logic [7:0] literal = '0, alu_operand = '0, status_wdata = '0, wacc_wdata = '0;
   logic [7:0] pc_low_in = '0, latch_wdata = '0;
   logic [3:0] bank_wdata = '0;
   logic [20:0] tptr_wdata = '0;
   logic [15:0] prog_word;
   logic stack_full_flag, stack_underflow_flag, device_reset, pc_low_load, return_pop;
   logic prog_wr_en;
   logic [7:0] alu_result, alu_flags, working_accumulator, pc_low_byte, table_latch;
   logic [7:0] prog_wr_byte;
   logic [3:0] bank_select_reg;
   logic [20:0] table_pointer;

   always #5 clk = ~clk;

   csf_core #(.RST_CYCLES(4)) dut (.clk, .rst, .stack_reset_enable, .stack_full_evt,
      .stack_underflow_evt, .stack_full_flag_clr, .stack_underflow_flag_clr, .stack_full_flag,
      .stack_underflow_flag, .device_reset, .irq_vector, .fast_call, .interrupt_return_instr,
      .fast_return, .return_literal_instr, .literal, .alu_en, .alu_op, .alu_operand,
      .alu_src_status, .dest_status, .dest_working_accumulator, .status_wr, .status_wdata, .wacc_wr,
      .wacc_wdata, .bank_wr, .bank_wdata, .alu_result, .alu_flags, .working_accumulator,
      .bank_select_reg, .add_w_to_file, .pc_low_in, .pc_low_byte, .pc_low_load, .return_pop,
      .tptr_wr, .tptr_wdata, .tbl_rd, .tbl_wr, .tbl_inc, .prog_word, .latch_wr,
      .latch_wdata, .table_pointer, .table_latch, .prog_wr_byte, .prog_wr_en);

   csf_prog_mem_model mem (.table_pointer, .prog_word);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [31:0] seen(string n);
      case (n)
         "flags": return 32'(alu_flags);
         "w": return 32'(working_accumulator);
         "bank": return 32'(bank_select_reg);
         "result": return 32'(alu_result);
         "full": return 32'(stack_full_flag);
         "unf": return 32'(stack_underflow_flag);
         "pop": return 32'(return_pop);
         "pc": return 32'({pc_low_load, pc_low_byte});
         "latch": return 32'(table_latch);
         "ptr": return 32'(table_pointer);
         "pwr": return 32'({prog_wr_en, prog_wr_byte});
         default: return 32'hdead_beef;
      endcase
   endfunction : seen

   task automatic check(string n, logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask : check

   task automatic note(string n, logic [31:0] v);
      notes.push_back('{n, v});
   endtask : note

   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   // Results sampled mid-cycle, where the launching edge has settled
   always @(negedge clk) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         check(nt.n, seen(nt.n), nt.v);
      end
   end

   // Ends at the edge that samples the request, dropping every strobe
   task automatic go();
      @(posedge clk);
      {stack_full_evt, stack_underflow_evt, stack_full_flag_clr, stack_underflow_flag_clr} <= '0;
      {irq_vector, fast_call, interrupt_return_instr, fast_return, return_literal_instr} <= '0;
      {alu_en, alu_src_status, dest_status, dest_working_accumulator, status_wr, wacc_wr, bank_wr} <= '0;
      {add_w_to_file, tptr_wr, tbl_rd, tbl_wr, tbl_inc, latch_wr} <= '0;
   endtask : go

   // Status altered by direct write only, so no flag side effect muddles the setup
   task automatic put(logic [7:0] w, logic [7:0] s, logic [3:0] b);
      @(posedge clk);
      {wacc_wr, status_wr, bank_wr} <= 3'h7;
      {wacc_wdata, status_wdata, bank_wdata} <= {w, s, b};
      go();
   endtask : put

   task automatic fast_stack(bit irq);
      logic [31:0] r;
      r = rnd();
      // Interrupt case nests a second entry before the single restore
      // Only the latest save survives, usable because no priority split is modelled
      repeat (irq ? 2 : 1) begin
         r = rnd();
         put(r[7:0], r[15:8], r[19:16]);
         @(posedge clk);
         irq_vector <= irq;
         fast_call <= !irq;
         go();
         put(~r[7:0], ~r[15:8], ~r[19:16]);
      end
      @(posedge clk);
      fast_return <= 1'b1;
      interrupt_return_instr <= irq;
      go();
      note("w", 32'(r[7:0]));
      note("flags", 32'(r[15:8] & 8'h1f));
      note("bank", 32'(r[19:16]));
      note("pop", 32'h1);
   endtask : fast_stack

   task automatic fault(bit en, bit full);
      int n;
      n = 0;
      @(posedge clk);
      stack_reset_enable <= en;
      {stack_full_evt, stack_underflow_evt} <= {full, !full};
      go();
      repeat (12) begin
         @(negedge clk);
         n += int'(device_reset === 1'b1);
      end
      check("reset_cycles", 32'(n), en ? 32'h4 : 32'h0);
      @(posedge clk);
      note("full", 32'(full));
      note("unf", 32'(!full));
      @(posedge clk);
      {stack_full_flag_clr, stack_underflow_flag_clr} <= {full, !full};
      go();
      note("full", 32'h0);
      note("unf", 32'h0);
   endtask : fault

   task automatic alu(logic [2:0] op, logic [7:0] opd, bit src, bit ds);
      @(posedge clk);
      {alu_en, alu_op, alu_operand} <= {1'b1, op, opd};
      {alu_src_status, dest_status, dest_working_accumulator} <= {src, ds, !ds};
      go();
   endtask : alu

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r;
      logic [20:0] a;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      note("flags", 32'h0);
      note("w", 32'h0);
      note("full", 32'h0);
      fast_stack(1'b0);
      fast_stack(1'b1);
      fault(1'b1, 1'b1);
      fault(1'b0, 1'b0);
      put(8'h00, 8'hff, 4'h0);
      note("flags", 32'h1f);
      put(8'h7f, 8'h00, 4'h0);
      alu(csf_pkg::CSF_OP_ADD, 8'h01, 1'b0, 1'b0);
      note("result", 32'h80);
      note("flags", 32'h1a);
      put(8'h30, 8'h00, 4'h0);
      alu(csf_pkg::CSF_OP_SUB, 8'h30, 1'b0, 1'b0);
      note("flags", 32'h07);
      put(8'h55, 8'h12, 4'h0);
      alu(csf_pkg::CSF_OP_CLR, 8'h00, 1'b0, 1'b1);
      note("flags", 32'h16);
      note("w", 32'h55);
      put(8'h00, 8'h0b, 4'h0);
      alu(csf_pkg::CSF_OP_AND, 8'hff, 1'b1, 1'b0);
      note("w", 32'h0b);
      // Move leaves the flags alone, so its result lands in status
      put(8'h01, 8'h00, 4'h0);
      alu(csf_pkg::CSF_OP_MOV, 8'h3c, 1'b0, 1'b1);
      note("flags", 32'h1c);
      alu(csf_pkg::CSF_OP_IOR, 8'h80, 1'b0, 1'b0);
      note("w", 32'h81);
      note("flags", 32'h18);
      alu(csf_pkg::CSF_OP_XOR, 8'h81, 1'b0, 1'b0);
      note("w", 32'h00);
      note("flags", 32'h0c);
      // Even offset only, as the caller must supply
      put(8'h06, 8'h00, 4'h0);
      @(posedge clk);
      {add_w_to_file, pc_low_in} <= {1'b1, 8'hfc};
      go();
      note("pc", 32'h102);
      r = rnd();
      @(posedge clk);
      {return_literal_instr, fast_return, literal} <= {2'b11, r[7:0]};
      go();
      note("w", 32'(r[7:0]));
      note("pop", 32'h1);
      a = r[28:8] & ~21'h1;
      @(posedge clk);
      {tptr_wr, tptr_wdata} <= {1'b1, a};
      go();
      @(posedge clk);
      {tbl_rd, tbl_inc} <= 2'b11;
      go();
      note("latch", 32'(a[8:1]));
      note("ptr", 32'(a + 21'h1));
      @(posedge clk);
      {tbl_rd, tbl_inc} <= 2'b11;
      go();
      note("latch", 32'(a[8:1] ^ 8'h5a));
      @(posedge clk);
      {latch_wr, latch_wdata} <= {1'b1, r[31:24]};
      go();
      @(posedge clk);
      tbl_wr <= 1'b1;
      go();
      note("pwr", 32'({1'b1, r[31:24]}));
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule : csf_core_tb
